// [hw/ldi_pkg.sv]
package ldi_pkg;

   // ************************************************
   // Target address and subaddress commands
   // ************************************************
   localparam logic [3:0] GROUP_CODE  = 4'hA;  // Arbitrary value
   localparam logic [7:0] SUB_WRITE   = 8'h11;
   localparam logic [7:0] SUB_XFER    = 8'h22;
   localparam logic [7:0] SUB_WR_XFER = 8'h44;

   // ************************************************
   // Reset values and bit counts
   // ************************************************
   localparam logic [7:0] DSR_RST     = 8'h00;
   localparam logic [7:0] OSR_RST     = 8'h00;
   localparam logic [7:0] SUB_RST     = 8'h00;
   localparam logic [7:0] IDLE_BYTE   = 8'hFF;
   localparam logic [3:0] BYTE_BITS   = 4'h8;

   // ************************************************
   // Serial engine states
   // ************************************************
   typedef enum logic [9:0] {
      ST_IDLE     = 10'h001,
      ST_ADDR     = 10'h002,
      ST_ADDR_ACK = 10'h004,
      ST_SUB      = 10'h008,
      ST_SUB_ACK  = 10'h010,
      ST_DATA     = 10'h020,
      ST_DATA_ACK = 10'h040,
      ST_RD       = 10'h080,
      ST_RD_ACK   = 10'h100,
      ST_IGNORE   = 10'h200
   } ldi_state_t;

   typedef struct packed {
      logic       scl_s1;
      logic       scl_s2;
      logic       scl_s3;
      logic       sda_s1;
      logic       sda_s2;
      logic       sda_s3;
      logic [2:0] pin_s1;
      logic [2:0] pin_s2;
      ldi_state_t st;
      logic [3:0] cnt;
      logic [7:0] rx;
      logic [7:0] sub;
      logic       rw;
      logic [7:0] dsr;
      logic [7:0] osr;
      logic [7:0] tx;
      logic       oe;
   } ldi_regs_t;

endpackage : ldi_pkg

// [hw/ldi_target.sv]
// Contract
// [R1] Subaddress 11H read returns shift register
// [R2] 11H write loads shift register only
// [R3] 22H write copies shift to output
// [R4] 44H write loads then copies to output
// [R5] Other subaddresses change no register
// [R6] Undefined subaddress gets no acknowledge
// [R7] Address is group code plus pins
// [R8] 22H copy during subaddress acknowledge
// [R9] 44H copy during data acknowledge
// [R10] 44H with read direction is ignored
// [R11] Output bit one turns channel on
`timescale 1ns/1ps
`default_nettype none

module ldi_target (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   // Serial bus pins
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe,
   // Address select pins
   input  wire logic [2:0] addr_pins,
   // Output channels
   output logic [7:0]      chan_on
);

   // ************************************************
   // State
   // ************************************************
   ldi_pkg::ldi_regs_t r_q;
   ldi_pkg::ldi_regs_t r_d;

   // Subaddresses that are acknowledged and acted on
   function automatic logic sub_known(input logic [7:0] s);
      sub_known = (s == ldi_pkg::SUB_WRITE) || (s == ldi_pkg::SUB_XFER) ||
                  (s == ldi_pkg::SUB_WR_XFER);
   endfunction : sub_known

   // Byte offered on a read; anything but 11H leaves the line released
   function automatic logic [7:0] rd_byte(input logic [7:0] s, input logic [7:0] d);
      rd_byte = (s == ldi_pkg::SUB_WRITE) ? d : ldi_pkg::IDLE_BYTE;
   endfunction : rd_byte

   // Edge and condition detection on synchronised pins
   // Start and stop need the clock high in both samples, so a data
   // change while the clock is low is never taken for a condition
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   assign scl_rise = r_q.scl_s2 & ~r_q.scl_s3;
   assign scl_fall = ~r_q.scl_s2 & r_q.scl_s3;
   assign start_c  = r_q.scl_s2 & r_q.scl_s3 & r_q.sda_s3 & ~r_q.sda_s2;
   assign stop_c   = r_q.scl_s2 & r_q.scl_s3 & ~r_q.sda_s3 & r_q.sda_s2;

   // ************************************************
   // Next state
   // ************************************************
   always_comb begin
      logic [7:0] tx_n;
      logic [7:0] rd_n;
      tx_n = r_q.tx << 1;
      rd_n = rd_byte(r_q.sub, r_q.dsr);
      r_d = r_q;
      r_d.scl_s1 = scl_i;
      r_d.scl_s2 = r_q.scl_s1;
      r_d.scl_s3 = r_q.scl_s2;
      r_d.sda_s1 = sda_i;
      r_d.sda_s2 = r_q.sda_s1;
      r_d.sda_s3 = r_q.sda_s2;
      r_d.pin_s1 = addr_pins;
      r_d.pin_s2 = r_q.pin_s1;
      if (start_c) begin
         // Repeated start restarts the address phase from any state
         r_d.st  = ldi_pkg::ST_ADDR;
         r_d.cnt = 4'h0;
         r_d.oe  = 1'b0;
      end else if (stop_c) begin
         // Stop ends any transfer and lets the data line go
         r_d.st = ldi_pkg::ST_IDLE;
         r_d.oe = 1'b0;
      end else begin
         case (r_q.st)
            ldi_pkg::ST_ADDR, ldi_pkg::ST_SUB, ldi_pkg::ST_DATA: begin
               if (scl_rise) begin
                  r_d.rx  = {r_q.rx[6:0], r_q.sda_s2};
                  r_d.cnt = r_q.cnt + 4'h1;
               end else if (scl_fall && r_q.cnt == ldi_pkg::BYTE_BITS) begin
                  r_d.cnt = 4'h0;
                  if (r_q.st == ldi_pkg::ST_ADDR) begin
                     if (r_q.rx[7:1] == {ldi_pkg::GROUP_CODE, r_q.pin_s2}) begin  // R7
                        r_d.st = ldi_pkg::ST_ADDR_ACK;
                        r_d.rw = r_q.rx[0];
                        r_d.oe = 1'b1;
                     end else begin
                        // Not ours: stay silent until the next start or stop
                        r_d.st = ldi_pkg::ST_IGNORE;
                     end
                  end else if (r_q.st == ldi_pkg::ST_SUB) begin
                     r_d.sub = r_q.rx;
                     r_d.st  = ldi_pkg::ST_SUB_ACK;
                     r_d.oe  = sub_known(r_q.rx);  // R6
                     if (r_q.rx == ldi_pkg::SUB_XFER) begin
                        r_d.osr = r_q.dsr;  // R3 R8
                     end
                  end else begin
                     r_d.st = ldi_pkg::ST_DATA_ACK;
                     r_d.oe = 1'b1;
                     // Only 11H and 44H reach here; others are dropped
                     r_d.dsr = r_q.rx;  // R2 R4
                     if (r_q.sub == ldi_pkg::SUB_WR_XFER) begin
                        r_d.osr = r_q.rx;  // R9
                     end
                  end
               end
            end
            ldi_pkg::ST_ADDR_ACK: begin
               if (scl_fall) begin
                  // Direction from the address byte, subaddress from the last write
                  if (r_q.rw) begin
                     // Only 11H exposes the shift register; 44H read is ignored
                     r_d.tx = rd_n;  // R1 R10
                     r_d.oe = ~rd_n[7];
                     r_d.st = ldi_pkg::ST_RD;
                  end else begin
                     r_d.oe = 1'b0;
                     r_d.st = ldi_pkg::ST_SUB;
                  end
               end
            end
            ldi_pkg::ST_SUB_ACK: begin
               if (scl_fall) begin
                  r_d.oe = 1'b0;
                  // Data after 22H or an unknown code is ignored
                  if (r_q.sub == ldi_pkg::SUB_WRITE || r_q.sub == ldi_pkg::SUB_WR_XFER) begin
                     r_d.st = ldi_pkg::ST_DATA;  // R5
                  end else begin
                     r_d.st = ldi_pkg::ST_IGNORE;
                  end
               end
            end
            ldi_pkg::ST_DATA_ACK: begin
               // Further bytes keep loading under the same subaddress
               if (scl_fall) begin
                  r_d.oe = 1'b0;
                  r_d.st = ldi_pkg::ST_DATA;
               end
            end
            ldi_pkg::ST_RD: begin
               // Count rises; the fall after the eighth hands the slot over
               if (scl_rise) begin
                  r_d.cnt = r_q.cnt + 4'h1;
               end else if (scl_fall) begin
                  if (r_q.cnt == ldi_pkg::BYTE_BITS) begin
                     r_d.cnt = 4'h0;
                     r_d.oe  = 1'b0;
                     r_d.st  = ldi_pkg::ST_RD_ACK;
                  end else begin
                     r_d.tx = tx_n;
                     r_d.oe = ~tx_n[7];
                  end
               end
            end
            ldi_pkg::ST_RD_ACK: begin
               // Controller not-acknowledge ends the read
               if (scl_rise && r_q.sda_s2) begin
                  r_d.st = ldi_pkg::ST_IGNORE;
               end else if (scl_fall) begin
                  r_d.tx = rd_n;  // R1
                  r_d.oe = ~rd_n[7];
                  r_d.st = ldi_pkg::ST_RD;
               end
            end
            ldi_pkg::ST_IDLE, ldi_pkg::ST_IGNORE: begin
               r_d.oe = 1'b0;
            end
            default: begin
               r_d.st = ldi_pkg::ST_IDLE;
               r_d.oe = 1'b0;
            end
         endcase
      end
   end

   // ************************************************
   // Registers, power-up idle state
   // ************************************************
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         r_q        <= '0;
         // Clock and data samplers preload idle-high so release makes no false edge
         r_q.scl_s1 <= 1'b1;
         r_q.scl_s2 <= 1'b1;
         r_q.scl_s3 <= 1'b1;
         r_q.sda_s1 <= 1'b1;
         r_q.sda_s2 <= 1'b1;
         r_q.sda_s3 <= 1'b1;
         r_q.st     <= ldi_pkg::ST_IDLE;
         r_q.sub    <= ldi_pkg::SUB_RST;
         r_q.dsr    <= ldi_pkg::DSR_RST;
         r_q.osr    <= ldi_pkg::OSR_RST;
         r_q.tx     <= ldi_pkg::IDLE_BYTE;
      end else begin
         r_q <= r_d;
      end
   end

   // ************************************************
   // Outputs
   // ************************************************
   // Open drain: only ever pulls low, the pull-up gives the high level
   assign sda_o   = 1'b0;
   assign sda_oe  = r_q.oe;
   assign chan_on = r_q.osr;  // R11

endmodule : ldi_target

`default_nettype wire

// [dv/ldi_target_props.sv]
`timescale 1ns/1ps
`default_nettype none
module ldi_props (
   // Clock and reset
   input wire logic       ref_clk,
   input wire logic       rst_b,
   // Pins
   input wire logic       scl_i,
   input wire logic       sda_i,
   input wire logic       sda_o,
   input wire logic       sda_oe,
   input wire logic [2:0] addr_pins,
   input wire logic [7:0] chan_on
);
   // One clock domain
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // Data pin only ever pulled low, and only moved while the clock is low
   a_drive_zero: assert property (sda_oe |-> sda_o == 1'h0 && !sda_i) else $error("sda not pulled low");
   a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i) else $error("oe moved");
   a_ack_holds: assert property ($rose(sda_oe) |-> sda_oe [*8]) else $error("short drive");
   // Copies land only inside an acknowledge slot
   a_chan_scl_low: assert property ($changed(chan_on) |-> !scl_i) else $error("chan moved");
   a_copy_in_ack: assert property ($changed(chan_on) |-> ##[0:3] sda_oe) else $error("copy off ack");
   // Quiet after reset and around bus conditions
   a_reset_quiet: assert property ($rose(rst_b) |-> !sda_oe [*8]) else $error("drive at reset");
   a_start_quiet: assert property ($fell(sda_i) && scl_i |-> !sda_oe [*8]) else $error("drive at start");
   a_stop_quiet: assert property ($rose(sda_i) && scl_i |-> ##4 !sda_oe) else $error("drive at stop");
endmodule : ldi_props
bind ldi_target ldi_props ldi_props_i (.ref_clk(ref_clk), .rst_b(rst_b), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe(sda_oe), .addr_pins(addr_pins), .chan_on(chan_on));
`default_nettype wire

// [dv/ldi_ctl.sv]
`timescale 1ns/1ps
`default_nettype none
module ldi_ctl (
   // Bus lines
   output var logic scl,
   output var logic sda_m,
   input  wire logic sda
);
   // Idle bus; the clock stands still between frames
   initial {scl, sda_m} = 2'h3;
   // Start (0) or stop (1): data moves while the clock is high
   // Non-blocking, so a change that lands on a sampling edge is race free
   task automatic cond(input logic s);
      #15 sda_m <= ~s;
      #47.5 scl <= 1'h1;
      #62.5 sda_m <= s;
      #62.5 scl <= s;
   endtask : cond
   // Set early in the low half, read late in the high half
   task automatic xfer_bit(input logic b, output logic r);
      #15 sda_m <= b;
      #47.5 scl <= 1'h1;
      #62.5 r = sda;
      scl <= 1'h0;
   endtask : xfer_bit
   // MSB first; a is what the controller puts in the acknowledge slot
   task automatic xfer_byte(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(d[i], q[i]);
      end
      xfer_bit(a, k);
   endtask : xfer_byte
endmodule : ldi_ctl
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic       ref_clk, rst_b, scl, sda_m, sda_o, sda_oe, ka, ks, kd;
   logic [2:0] addr_pins;
   logic [7:0] chan_on, q;
   wire        sda;
   int         bad_count, num_checks;
   // Pull-up on the data wire
   assign sda = sda_m & ~sda_oe;
   ldi_target ldi_target_i (.ref_clk(ref_clk), .rst_b(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .addr_pins(addr_pins), .chan_on(chan_on));
   ldi_ctl ldi_ctl_i (.scl(scl), .sda_m(sda_m), .sda(sda));
   always #5 ref_clk = ~ref_clk;
   // Compare and count
   task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task automatic wrap_up;
      if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   // Address byte, direction in bit 0
   function automatic logic [7:0] adr(input logic r);
      return {ldi_pkg::GROUP_CODE, addr_pins, r};
   endfunction : adr
   task automatic xb(input logic [7:0] d, output logic k);
      ldi_ctl_i.xfer_byte(d, 1'h1, q, k);
   endtask : xb
   // Address, subaddress, then a data byte; a read repeats the start first
   task automatic frame(input logic [7:0] a, s, d, input logic rd);
      ldi_ctl_i.cond(1'h0);
      xb(a, ka);
      xb(s, ks);
      if (rd) ldi_ctl_i.cond(1'h0);
      if (rd) xb(adr(1'h1), ka);
      xb(d, kd);
      ldi_ctl_i.cond(1'h1);
   endtask : frame
   task automatic t_shift;
      frame(adr(1'h0), 8'h11, 8'hA5, 1'h0);
      check("acks", {5'h0, ka, ks, kd}, 8'h00);
      check("chan", chan_on, 8'h00);
      frame(adr(1'h0), 8'h11, 8'hFF, 1'h1);
      check("read", q, 8'hA5);
   endtask : t_shift
   // Copy seen inside the acknowledge; trailing byte refused
   task automatic t_xfer;
      ldi_ctl_i.cond(1'h0);
      xb(adr(1'h0), ka);
      xb(8'h22, ks);
      check("chan", chan_on, 8'hA5);
      xb(8'h5A, kd);
      ldi_ctl_i.cond(1'h1);
      check("acks", {5'h0, ka, ks, kd}, 8'h01);
      frame(adr(1'h0), 8'h11, 8'hFF, 1'h1);
      check("shift", q, 8'hA5);
   endtask : t_xfer
   task automatic t_comb;
      frame(adr(1'h0), 8'h44, 8'h3C, 1'h0);
      check("acks", {5'h0, ka, ks, kd}, 8'h00);
      check("chan", chan_on, 8'h3C);
      frame(adr(1'h0), 8'h44, 8'hFF, 1'h1);
      check("read", q, 8'hFF);
      check("chan", chan_on, 8'h3C);
   endtask : t_comb
   task automatic t_undef;
      logic [7:0] subs [4] = '{8'h00, 8'h12, 8'h33, 8'hFF};
      foreach (subs[i]) begin
         frame(adr(1'h0), subs[i], 8'h96, 1'h0);
         check("nack", {5'h0, ka, ks, kd}, 8'h03);
      end
      check("chan", chan_on, 8'h3C);
      frame(adr(1'h0), 8'h11, 8'hFF, 1'h1);
      check("shift", q, 8'h3C);
   endtask : t_undef
   task automatic t_addr;
      frame({~ldi_pkg::GROUP_CODE, addr_pins, 1'h0}, 8'h44, 8'h00, 1'h0);
      check("group", {7'h0, ka}, 8'h01);
      @(posedge ref_clk) addr_pins <= 3'h5;
      frame({ldi_pkg::GROUP_CODE, 3'h2, 1'h0}, 8'h44, 8'h00, 1'h0);
      check("pins", {7'h0, ka}, 8'h01);
      frame(adr(1'h0), 8'h44, 8'h81, 1'h0);
      check("chan", chan_on, 8'h81);
   endtask : t_addr
   // Direct read of two bytes, controller acknowledging the first
   task automatic t_burst;
      frame(adr(1'h0), 8'h11, 8'h66, 1'h0);
      ldi_ctl_i.cond(1'h0);
      xb(adr(1'h1), ka);
      ldi_ctl_i.xfer_byte(8'hFF, 1'h0, q, kd);
      check("first", q, 8'h66);
      ldi_ctl_i.xfer_byte(8'hFF, 1'h1, q, kd);
      ldi_ctl_i.cond(1'h1);
      check("again", q, 8'h66);
      check("acks", {6'h0, ka, kd}, 8'h01);
      check("chan", chan_on, 8'h81);
   endtask : t_burst
   initial begin
      ref_clk = 1'h0;
      rst_b = 1'h0;
      addr_pins = 3'h2;
      repeat (16) @(posedge ref_clk);
      rst_b <= 1'h1;
      repeat (8) @(posedge ref_clk);
      t_shift();
      t_xfer();
      t_comb();
      t_undef();
      t_addr();
      t_burst();
      wrap_up();
   end
   // Watchdog, several times the expected run
   initial begin
      #600000;
      bad_count++;
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
